// *** hdl/osc_select_pkg.sv ***
// Function
// - Switchover bit one with select 010, 011 or 100 starts on internal clock, then switches external; zero disables.
// - Slow RC power bit one gives high power accuracy; zero low power.
// - Secondary source bit one drives crystal pins; zero takes digital clock input.
// - Select 000 fast RC, 001 divided fast RC PLL, 010 primary, 011 primary PLL.
// - Select 100 picks secondary oscillator, 101 picks slow internal RC.
// - Select 110 picks low-power fast RC divided, 111 picks 8 MHz divided.
// - Bits four and three of the configuration byte always read zero.
package osc_select_pkg;
  localparam logic [7:0] CFG_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] CTRL_OFFSET = 8'h08;
  localparam int BIT_TWO_SPEED = 7;
  localparam int BIT_SLOW_RC_PWR = 6;
  localparam int BIT_SEC_SRC = 5;
  localparam logic [7:0] CFG_RESET = 8'he7;
  localparam logic [7:0] CFG_IMPL_MASK = 8'he7;
  localparam int SWITCH_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SWITCH_CYCLES = (SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [2:0] {
    SRC_FAST_RC, SRC_FAST_RC_DIV_PLL, SRC_PRIMARY, SRC_PRIMARY_PLL,
    SRC_SECONDARY, SRC_SLOW_RC, SRC_LP_FAST_RC_DIV, SRC_FAST_RC_DIV
  } osc_src_type;
endpackage

// *** hdl/cfg_load_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface cfg_load_if;
  logic load;
  logic [7:0] data;
  modport src (output load, output data);
  modport dst (input load, input data);
endinterface
`default_nettype wire

// *** hdl/osc_cfg_latch.sv ***
`timescale 1ns/10ps
`default_nettype none
module osc_cfg_latch (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] nv_cfg_byte,
  cfg_load_if.src load_port
);
  import osc_select_pkg::*;
  logic [7:0] data_q;
  logic load_q;
  // Strap is caught by a clocked process while reset is held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_q <= nv_cfg_byte & CFG_IMPL_MASK;
      load_q <= 1'b1;
    end else begin
      load_q <= 1'b0;
    end
  end
  assign load_port.load = load_q;
  assign load_port.data = data_q;
endmodule
`default_nettype wire

// *** hdl/osc_select_config.sv ***
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module osc_select_config #(
  parameter int SWITCH_CYCLES_P = osc_select_pkg::SWITCH_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] nv_cfg_byte,
  input wire logic ext_clk_ready,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [2:0] active_osc_sel,
  output logic slow_rc_high_power,
  output logic sec_osc_crystal_en,
  output logic secondary_digital_clk_in_en,
  output logic core_reset_n
);
  import osc_select_pkg::*;

  // ****************************************
  // Configuration capture
  // ****************************************
  // The latch hands the strap over once, on the first edge after reset.
  cfg_load_if cfg_bus();
  osc_cfg_latch u_latch (
    .aclk(aclk),
    .aresetn(aresetn),
    .nv_cfg_byte(nv_cfg_byte),
    .load_port(cfg_bus)
  );

  logic [7:0] cfg_q;
  logic [2:0] active_q;
  logic two_speed_q;
  logic [15:0] wait_q;
  logic core_rst_q;
  logic [7:0] ctrl_q;
  wire [2:0] initial_osc_sel = cfg_q[2:0];
  wire two_speed_startup_en = cfg_q[BIT_TWO_SPEED];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= CFG_RESET;
    end else if (cfg_bus.load) begin
      cfg_q <= cfg_bus.data;
    end
  end

  // ****************************************
  // Clock source sequencing
  // ****************************************
  // Two-speed start runs the fast RC until the external source is ready and the minimum dwell is done.
  wire ext_src = (initial_osc_sel == SRC_PRIMARY) || (initial_osc_sel == SRC_PRIMARY_PLL) ||
                 (initial_osc_sel == SRC_SECONDARY);
  wire use_two_speed = two_speed_startup_en && ext_src;
  // The dwell counter stops once the wait is done, so it cannot wrap.
  wire wait_done = (wait_q >= 16'(SWITCH_CYCLES_P));
  // The switch needs both the ready pin and the minimum dwell on the fast RC.
  wire switch_now = two_speed_q && ext_clk_ready && wait_done;

  always_ff @(posedge aclk) begin
    if (!aresetn || cfg_bus.load) begin
      active_q <= SRC_FAST_RC;
      two_speed_q <= 1'b0;
      wait_q <= 16'h0000;
      core_rst_q <= 1'b0;
    end else if (!core_rst_q) begin
      // Core leaves reset only once the chosen source is applied.
      active_q <= use_two_speed ? 3'(SRC_FAST_RC) : initial_osc_sel;
      two_speed_q <= use_two_speed;
      core_rst_q <= 1'b1;
    end else if (switch_now) begin
      active_q <= initial_osc_sel;
      two_speed_q <= 1'b0;
    end else if (two_speed_q && !wait_done) begin
      wait_q <= wait_q + 16'h0001;
    end
  end

  assign active_osc_sel = active_q;
  assign slow_rc_high_power = cfg_q[BIT_SLOW_RC_PWR];
  assign sec_osc_crystal_en = cfg_q[BIT_SEC_SRC];
  assign secondary_digital_clk_in_en = ~cfg_q[BIT_SEC_SRC];
  assign core_reset_n = core_rst_q;

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic aw_q, w_q, bv_q, rv_q;
  logic [7:0] awa_q;
  logic [31:0] wd_q, rd_q;
  logic [3:0] ws_q;
  logic [1:0] br_q, rr_q;

  assign s_axi_awready = !aw_q && !bv_q;
  assign s_axi_wready = !w_q && !bv_q;
  assign s_axi_arready = !rv_q;
  wire do_write = aw_q && w_q && !bv_q;
  wire wr_ctrl = (awa_q == CTRL_OFFSET);
  wire wr_ro = (awa_q == CFG_OFFSET) || (awa_q == STATUS_OFFSET);
  // Only the low address byte selects a word; the higher bits must be zero.
  wire [7:0] ara = s_axi_araddr[7:0];
  wire ar_hi_ok = (s_axi_araddr[31:8] == 24'h000000);
  // Status word: active source, core released and two-speed start in progress.
  wire [31:0] status_word = {23'h0, two_speed_q, core_rst_q, 4'h0, active_q};
  wire [31:0] cfg_word = {24'h000000, cfg_q & CFG_IMPL_MASK};
  wire [31:0] rd_sel;
  wire rd_ok;
  assign rd_ok = ar_hi_ok && ((ara == CFG_OFFSET) || (ara == STATUS_OFFSET) ||
                              (ara == CTRL_OFFSET));
  // Reads outside the three words answer an error with zero data.
  assign rd_sel = !rd_ok ? 32'h00000000 :
                  (ara == CFG_OFFSET) ? cfg_word :
                  (ara == STATUS_OFFSET) ? status_word : {24'h000000, ctrl_q};

  // ****************************************
  // Write address and data capture
  // ****************************************
  // Address and data are held apart, so the master may offer them in either order.
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire b_done = bv_q && s_axi_bready;
  wire aw_in_range = (s_axi_awaddr[31:8] == 24'h000000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      awa_q <= 8'h00;
    end else if (aw_take) begin
      aw_q <= 1'b1;
      awa_q <= aw_in_range ? s_axi_awaddr[7:0] : 8'hff;
    end else if (do_write) begin
      aw_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_q <= 1'b0;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
    end else if (w_take) begin
      w_q <= 1'b1;
      wd_q <= s_axi_wdata;
      ws_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_q <= 1'b0;
    end
  end

  // ****************************************
  // Write response and scratch register
  // ****************************************
  // Writes to the read-only words are acknowledged and dropped.
  wire [1:0] wr_resp = (wr_ctrl || wr_ro) ? RESP_OKAY : RESP_SLVERR;
  wire ctrl_we = do_write && wr_ctrl && ws_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bv_q <= 1'b0;
      br_q <= RESP_OKAY;
    end else if (do_write) begin
      bv_q <= 1'b1;
      br_q <= wr_resp;
    end else if (b_done) begin
      bv_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= 8'h00;
    end else if (ctrl_we) begin
      ctrl_q <= wd_q[7:0];
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  // The read word is chosen when the address is taken and held until accepted.
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire r_done = rv_q && s_axi_rready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rv_q <= 1'b0;
      rd_q <= 32'h00000000;
      rr_q <= RESP_OKAY;
    end else if (ar_take) begin
      rv_q <= 1'b1;
      rd_q <= rd_sel;
      rr_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (r_done) begin
      rv_q <= 1'b0;
    end
  end

  // ****************************************
  // Bus outputs
  // ****************************************
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rr_q;
endmodule
`default_nettype wire

// *** tb/osc_select_config_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module osc_select_config_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] nv_cfg_byte,
  input wire logic ext_clk_ready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [2:0] active_osc_sel,
  input wire logic slow_rc_high_power,
  input wire logic sec_osc_crystal_en,
  input wire logic secondary_digital_clk_in_en,
  input wire logic core_reset_n
);
  logic ts;
  logic cfg_rd_q;
  assign ts = nv_cfg_byte[7] && nv_cfg_byte[2:0] inside {3'h2, 3'h3, 3'h4};
  always_ff @(posedge aclk) if (s_axi_arvalid && s_axi_arready) cfg_rd_q <= s_axi_araddr == 0;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_clk_in_inverse: assert property (sec_osc_crystal_en != secondary_digital_clk_in_en)
    else $error("clock input enable wrong");
  a_core_release: assert property ($rose(aresetn) |-> !core_reset_n ##[1:3] core_reset_n)
    else $error("core release wrong");
  a_slow_rc_mode: assert property (core_reset_n |-> slow_rc_high_power == nv_cfg_byte[6])
    else $error("slow rc mode wrong");
  a_crystal_mode: assert property (core_reset_n |-> sec_osc_crystal_en == nv_cfg_byte[5])
    else $error("crystal mode wrong");
  a_select_map: assert property (core_reset_n && !ts |->
    active_osc_sel == nv_cfg_byte[2:0]) else $error("source select wrong");
  a_two_speed_start: assert property ($rose(core_reset_n) && ts |-> active_osc_sel == 0)
    else $error("two-speed start wrong");
  a_switch_cause: assert property ($past(core_reset_n) && $changed(active_osc_sel) |->
    ts && $past(ext_clk_ready)) else $error("switch without cause");
  a_cfg_read: assert property (s_axi_rvalid && cfg_rd_q |->
    s_axi_rdata == {24'h0, nv_cfg_byte & 8'he7}) else $error("config read wrong");
  c_two_speed: cover property ($rose(core_reset_n) && ts);
  c_switch: cover property ($past(core_reset_n) && $changed(active_osc_sel));
  c_cfg_read: cover property (s_axi_rvalid && cfg_rd_q);
endmodule
bind osc_select_config osc_select_config_properties u_props (.*);
`default_nettype wire

// *** tb/oscillator_select_config_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module oscillator_select_config_tb_top;
  import osc_select_pkg::*;
  logic aclk = '0, aresetn = '0, ext_clk_ready = '0, s_axi_awvalid = '0, s_axi_wvalid = '0;
  logic s_axi_bready = '1, s_axi_arvalid = '0, s_axi_rready = '1, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, slow_rc_high_power, sec_osc_crystal_en;
  logic secondary_digital_clk_in_en, core_reset_n;
  logic [7:0] nv_cfg_byte = '0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] active_osc_sel;
  int failures = 0, n_compared = 0;
  wire [6:0] outs = {core_reset_n, slow_rc_high_power, sec_osc_crystal_en,
    secondary_digital_clk_in_en, active_osc_sel};
  osc_select_config #(.SWITCH_CYCLES_P(4)) DUT (.*);
  initial forever #10 aclk = ~aclk;
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic rd(input logic [31:0] a, output logic [33:0] rv);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    rv = {s_axi_rresp, s_axi_rdata};
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    chk(s_axi_bresp, RESP_OKAY);
  endtask
  task automatic boot(input logic [7:0] b);
    aresetn <= 1'h0;
    nv_cfg_byte <= b;
    ext_clk_ready <= 1'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
  endtask
  initial begin
    logic [7:0] b;
    logic [2:0] e;
    logic [33:0] rv;
    logic [31:0] d;
    void'($urandom(32'h406e));
    for (int i = 0; i < 16; i++) begin
      b = {i[3], 7'($urandom)};
      b[2:0] = i[2:0];
      e = (b[7] && b[2:0] inside {3'h2, 3'h3, 3'h4}) ? 3'h0 : b[2:0];
      boot(b);
      chk(outs, {1'h1, b[6], b[5], !b[5], e});
      rd(CFG_OFFSET, rv);
      chk(rv, {RESP_OKAY, 24'h0, b & 8'he7});
      ext_clk_ready <= 1'h1;
      repeat (20) @(posedge aclk);
      chk(active_osc_sel, b[2:0]);
    end
    wr(CFG_OFFSET, $urandom);
    rd(CFG_OFFSET, rv);
    chk(rv, {RESP_OKAY, 24'h0, b & 8'he7});
    rd(32'h10, rv);
    chk(rv, {RESP_SLVERR, 32'h0});
    d = $urandom;
    wr(CTRL_OFFSET, d);
    rd(CTRL_OFFSET, rv);
    chk(rv, {RESP_OKAY, 24'h0, d[7:0]});
    rd(STATUS_OFFSET, rv);
    chk(rv, {RESP_OKAY, 23'h0, 1'h0, 1'h1, 4'h0, b[2:0]});
    close_out();
  end
  // Sixteen boots need about 11 us; allow far more.
  initial begin
    #100000;
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
